//--- rtl/avl_logger.sv
// Mode select and access violation logger with an AXI4-Lite register slave
//
// Contract
// - External reset nrst is active low and holds mode logic in reset.
// - Mode bit loads from the mode-configuration pin when reset releases.
// - Mode bit only moves special to normal by write; readable always.
// - High code bits 7-4: initiator 0 none,1 CPU,3-4 converters,5 trigger.
// - Code high bits 3-0: target none, regs, RAM, EEPROM, flash, info row.
// - Code low bits 7-4 hold access kind: none, opcode, vector, load, store.
// - Code low bits 3-0 hold class: none, illegal range, uncorrectable ECC.
// - A CPU access violation loads a non-zero code into the pair.
// - Same cycle, capture the 24-bit program counter and flag snapshot.
// - A non-zero code blocks updates of code, counter and flag captures; a violation in the clearing write's cycle is still captured.
// - A 16-bit all-ones write clears the pair; other writes do nothing.
// - Flags high bit 7 holds the user/supervisor state at violation.
// - Flags low bit 6 holds the X-interrupt mask at violation.
// - Flags low bit 4 holds the I-interrupt mask; others read zero.
// - Flag bytes read anytime, never written, reset zero, set on new error.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "avl_params.svh"
module avl_logger
  import avl_pkg::*;
#(
  parameter int ADDR_W = 12               // AXI address width
) (
  input  wire logic              clk,          // System bus clock
  input  wire logic              nrst,         // External reset, active low
  input  wire logic              modeConfigPin,// Mode strap pin, async
  // Violation detect side, same clock
  input  wire logic              errStrobe,    // One-cycle violation pulse
  input  wire logic [3:0]        faultInitiator,// Requester code
  input  wire logic [3:0]        faultTarget,  // Target code
  input  wire logic [3:0]        faultOpKind,  // Access kind code
  input  wire logic [3:0]        faultClass,   // Violation class code
  input  wire logic [23:0]       cpuProgCounter,// CPU program counter
  input  wire logic              cpuUserState, // CPU user/supervisor bit
  input  wire logic              cpuXirqMask,  // CPU X-interrupt mask
  input  wire logic              cpuIrqMask,   // CPU I-interrupt mask
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,       // Write address
  input  wire logic              awvalid,      // Write address valid
  output logic                   awready,      // Write address ready
  input  wire logic [31:0]       wdata,        // Write data
  input  wire logic [3:0]        wstrb,        // Write byte lanes
  input  wire logic              wvalid,       // Write data valid
  output logic                   wready,       // Write data ready
  output logic [1:0]             bresp,        // Write response
  output logic                   bvalid,       // Write response valid
  input  wire logic              bready,       // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,       // Read address
  input  wire logic              arvalid,      // Read address valid
  output logic                   arready,      // Read address ready
  output logic [31:0]            rdata,        // Read data
  output logic [1:0]             rresp,        // Read response
  output logic                   rvalid,       // Read data valid
  input  wire logic              rready,       // Read data ready
  // Status outputs
  output logic                   irq,          // Level interrupt
  output logic                   opMode,       // 1 normal, 0 special
  output logic                   logHeld       // Error pair non-zero
);

  // Indexes span bits [9:2]; narrower buses cannot reach indexes 80h to FFh
  if (ADDR_W < 10 || ADDR_W > 32) begin
    // Refused at elaboration, so no logic is built for a bad width
    $error("avl_logger: ADDR_W must be 10 to 32");
  end


  // Word index of a byte address
  function automatic logic [7:0] regIndex(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  // True when the address falls on a word inside the 256-word window
  function automatic logic inWindow(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0);
    if (ADDR_W > 10) begin
      ok = ok && ((a >> 10) == '0);
    end
    return ok;
  endfunction

  // True when the index names a location this block answers
  function automatic logic isMapped(input logic [7:0] idx);
    return (idx == `AVL_IDX_MODE) || (idx == `AVL_IDX_IRQ_STAT) ||
           (idx == `AVL_IDX_IRQ_MASK) || (idx >= `AVL_IDX_CODE_HI);
  endfunction

  // Synchronised strap and boot sequencer
  logic                 modePinSync;
  avl_state_t           state;
  logic [1:0]           bootCnt;

  // Register state
  logic [7:0]           codeHi;
  logic [7:0]           codeLo;
  logic [7:0]           flagsHi;
  logic [7:0]           flagsLo;
  logic [23:0]          pcCapture;
  logic                 modeBit;
  logic [`AVL_IRQ_W-1:0] irqStat;
  logic [`AVL_IRQ_W-1:0] irqMask;

  // Write channel holding registers
  logic                 awHeld;
  logic                 wHeld;
  logic [ADDR_W-1:0]    awAddrQ;
  logic [31:0]          wDataQ;
  logic [3:0]           wStrbQ;

  // Decoded write
  logic                 doWrite;
  logic [7:0]           wrIdx;
  logic                 wrOk;
  logic                 clearPair;
  logic                 modeWrite;
  logic                 captureNow;
  logic                 modeSwitch;
  logic [`AVL_IRQ_W-1:0] next_irqStat;

  avl_sync u_sync (
    .clk     (clk),
    .nrst    (nrst),
    .pinIn   (modeConfigPin),
    .pinSync (modePinSync)
  );

  // Mode bit capture after release; reset itself only loads constants
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= AVL_ST_BOOT;
      bootCnt <= 2'h0;
    end else begin
      case (state)
        AVL_ST_BOOT: begin
          if (bootCnt == `AVL_BOOT_CNT) begin
            state <= AVL_ST_RUN;
          end else begin
            bootCnt <= bootCnt + 2'h1;
          end
        end
        AVL_ST_RUN: begin
          state <= AVL_ST_RUN;
        end
        default: begin
          state <= AVL_ST_BOOT;
        end
      endcase
    end
  end

  // Write decode
  assign doWrite   = awHeld && wHeld && !bvalid;
  assign wrIdx     = regIndex(awAddrQ);
  assign wrOk      = doWrite && inWindow(awAddrQ);
  // Pair clears only on a full 16-bit all-ones write at the pair address
  assign clearPair = wrOk && (wrIdx == `AVL_IDX_CODE_HI) &&
                     (wStrbQ[1:0] == 2'h3) &&
                     (wDataQ[15:0] == `AVL_CLEAR_KEY);
  // Only the special-to-normal step is taken
  assign modeWrite = wrOk && (wrIdx == `AVL_IDX_MODE) && wStrbQ[0] &&
                     (state == AVL_ST_RUN) &&
                     (modeBit == `AVL_MODE_SPECIAL) &&
                     (wDataQ[`AVL_MODE_BIT] == `AVL_MODE_NORMAL);
  assign modeSwitch = modeWrite;
  // Capture only a non-zero code, and only while the pair is empty or is being cleared in the same cycle
  assign captureNow = errStrobe &&
                      ({faultInitiator, faultTarget,
                        faultOpKind, faultClass} != 16'h0000) &&
                      (({codeHi, codeLo} == 16'h0000) || clearPair);

  // Mode bit: strap at boot, then one allowed step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeBit <= `AVL_MODE_SPECIAL;
    end else if (state == AVL_ST_BOOT && bootCnt == `AVL_BOOT_CNT) begin
      modeBit <= modePinSync;
    end else if (modeWrite) begin
      modeBit <= `AVL_MODE_NORMAL;
    end
  end

  // Error code pair; a violation in the clear cycle is kept
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codeHi <= `AVL_RST_BYTE;
      codeLo <= `AVL_RST_BYTE;
    end else if (captureNow) begin
      codeHi <= {faultInitiator, faultTarget};
      codeLo <= {faultOpKind, faultClass};
    end else if (clearPair) begin
      codeHi <= `AVL_RST_BYTE;
      codeLo <= `AVL_RST_BYTE;
    end
  end

  // Snapshot of CPU state, loaded with the code and never by software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flagsHi   <= `AVL_RST_BYTE;
      flagsLo   <= `AVL_RST_BYTE;
      pcCapture <= `AVL_RST_PC;
    end else if (captureNow) begin
      pcCapture <= cpuProgCounter;
      flagsHi   <= `AVL_RST_BYTE;
      flagsLo   <= `AVL_RST_BYTE;
      flagsHi[`AVL_USER_BIT]  <= cpuUserState;
      flagsLo[`AVL_XMASK_BIT] <= cpuXirqMask;
      flagsLo[`AVL_IMASK_BIT] <= cpuIrqMask;
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_comb begin
    next_irqStat = irqStat;
    if (wrOk && (wrIdx == `AVL_IDX_IRQ_STAT) && wStrbQ[0]) begin
      next_irqStat = irqStat & ~wDataQ[`AVL_IRQ_W-1:0];
    end
    if (captureNow) begin
      next_irqStat[`AVL_IRQ_LOGGED] = 1'b1;
    end
    if (modeSwitch) begin
      next_irqStat[`AVL_IRQ_MODESW] = 1'b1;
    end
  end

  // Interrupt status and mask
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqStat <= `AVL_RST_IRQ;
      irqMask <= `AVL_RST_IRQ;
    end else begin
      irqStat <= next_irqStat;
      if (wrOk && (wrIdx == `AVL_IDX_IRQ_MASK) && wStrbQ[0]) begin
        irqMask <= wDataQ[`AVL_IRQ_W-1:0];
      end
    end
  end

  // Registered status outputs; irq trails status by one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq     <= 1'b0;
      opMode  <= `AVL_MODE_SPECIAL;
      logHeld <= 1'b0;
    end else begin
      irq     <= |(irqStat & irqMask);
      opMode  <= modeBit;
      logHeld <= ({codeHi, codeLo} != 16'h0000);
    end
  end

  // Write channels: address and data taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      awHeld  <= 1'b0;
      wHeld   <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= 32'h00000000;
      wStrbQ  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `AVL_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld  <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld  <= 1'b0;
        bvalid <= 1'b1;
        // Gaps 84h and 88h-FFh answer OKAY and drop the data; other gaps answer SLVERR
        bresp  <= (inWindow(awAddrQ) && isMapped(wrIdx)) ?
                  `AVL_RESP_OKAY : `AVL_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read data mux; unnamed bits and gaps read zero
  function automatic logic [7:0] readByte(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `AVL_IDX_MODE:     v[`AVL_MODE_BIT] = modeBit;
      `AVL_IDX_IRQ_STAT: v[`AVL_IRQ_W-1:0] = irqStat;
      `AVL_IDX_IRQ_MASK: v[`AVL_IRQ_W-1:0] = irqMask;
      `AVL_IDX_CODE_HI:  v = codeHi;
      `AVL_IDX_CODE_LO:  v = codeLo;
      `AVL_IDX_FLAGS_HI: v = flagsHi;
      `AVL_IDX_FLAGS_LO: v = flagsLo;
      `AVL_IDX_PC_HI:    v = pcCapture[23:16];
      `AVL_IDX_PC_MID:   v = pcCapture[15:8];
      `AVL_IDX_PC_LO:    v = pcCapture[7:0];
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // Read channel: one read at a time, data one cycle after the address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `AVL_RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        if (inWindow(araddr) && isMapped(regIndex(araddr))) begin
          rdata <= {24'h000000, readByte(regIndex(araddr))};
          rresp <= `AVL_RESP_OKAY;
        end else begin
          rdata <= 32'h00000000;
          rresp <= `AVL_RESP_SLVERR;
        end
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

//--- rtl/avl_params.svh
// Offsets, field positions, reset values and counts of the violation logger
`ifndef AVL_PARAMS_SVH
`define AVL_PARAMS_SVH

// Register indexes; byte address on the bus is four times the index
`define AVL_IDX_MODE      8'h00
`define AVL_IDX_IRQ_STAT  8'h01
`define AVL_IDX_IRQ_MASK  8'h02
`define AVL_IDX_CODE_HI   8'h80
`define AVL_IDX_CODE_LO   8'h81
`define AVL_IDX_FLAGS_HI  8'h82
`define AVL_IDX_FLAGS_LO  8'h83
`define AVL_IDX_GAP_A     8'h84
`define AVL_IDX_PC_HI     8'h85
`define AVL_IDX_PC_MID    8'h86
`define AVL_IDX_PC_LO     8'h87
`define AVL_IDX_GAP_B_LO  8'h88
`define AVL_IDX_GAP_B_HI  8'hFF

// Field positions
`define AVL_MODE_BIT      0
`define AVL_USER_BIT      7
`define AVL_XMASK_BIT     6
`define AVL_IMASK_BIT     4
`define AVL_IRQ_LOGGED    0
`define AVL_IRQ_MODESW    1
`define AVL_IRQ_W         2

// Mode encodings and reset values
`define AVL_MODE_SPECIAL  1'b0
`define AVL_MODE_NORMAL   1'b1
`define AVL_CLEAR_KEY     16'hFFFF
`define AVL_RST_BYTE      8'h00
`define AVL_RST_PC        24'h000000
`define AVL_RST_IRQ       2'h0

// Edges after reset release before the synchronised pin is valid
`define AVL_BOOT_CNT      2'h2

// AXI responses
`define AVL_RESP_OKAY     2'h0
`define AVL_RESP_SLVERR   2'h2

`endif

//--- rtl/avl_pkg.sv
// Types of the access violation logger
package avl_pkg;

  // Who caused the violation
  typedef enum logic [3:0] {
    AVL_INIT_NONE = 4'h0,
    AVL_INIT_CPU  = 4'h1,
    AVL_INIT_CNV0 = 4'h3,
    AVL_INIT_CNV1 = 4'h4,
    AVL_INIT_TRIG = 4'h5
  } avl_init_t;

  // Mode capture sequencer, one-hot
  typedef enum logic [1:0] {
    AVL_ST_BOOT = 2'b01,
    AVL_ST_RUN  = 2'b10
  } avl_state_t;

endpackage

//--- rtl/avl_sync.sv
// Two-flop synchroniser for the mode-configuration pin
`timescale 1ns/1ps
module avl_sync (
  input  wire logic clk,      // System clock
  input  wire logic nrst,     // Async reset, active low
  input  wire logic pinIn,    // Asynchronous pin level
  output logic      pinSync   // Level safe to read in clk domain
);

  logic stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1  <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end

endmodule

//--- test/avl_cpu_model.sv
// CPU and violation-detect source driving the logger's fault port
`timescale 1ns/1ps
module avl_cpu_model (
  input  wire logic   clk,            // Clock
  output logic        errStrobe,      // Violation pulse
  output logic [3:0]  faultInitiator, // Requester
  output logic [3:0]  faultTarget,    // Target
  output logic [3:0]  faultOpKind,    // Access kind
  output logic [3:0]  faultClass,     // Class
  output logic [23:0] cpuProgCounter, // Program counter
  output logic        cpuUserState,   // User state
  output logic        cpuXirqMask,    // X mask
  output logic        cpuIrqMask      // I mask
);
  initial begin
    errStrobe = 1'b0;
    {faultInitiator, faultTarget, faultOpKind, faultClass} = 16'h0;
    cpuProgCounter = 24'h0;
    {cpuUserState, cpuXirqMask, cpuIrqMask} = 3'h0;
  end
  // Values hold for the strobe cycle only, then turn inverted so that a
  // capture on the wrong edge shows up
  task automatic fire(input logic [15:0] code, input logic [23:0] pc,
                      input logic [2:0] ccr);
    @(posedge clk);
    errStrobe <= 1'b1;
    {faultInitiator, faultTarget, faultOpKind, faultClass} <= code;
    cpuProgCounter <= pc;
    {cpuUserState, cpuXirqMask, cpuIrqMask} <= ccr;
    @(posedge clk);
    errStrobe <= 1'b0;
    {faultInitiator, faultTarget, faultOpKind, faultClass} <= ~code;
    cpuProgCounter <= ~pc;
    {cpuUserState, cpuXirqMask, cpuIrqMask} <= ~ccr;
  endtask
endmodule

//--- test/avl_logger_asserts.sv
// Port checker of the access violation logger
`timescale 1ns/1ps
module avl_logger_asserts (
  input wire logic       clk,            // Clock
  input wire logic       nrst,           // Reset, active low
  input wire logic       modeConfigPin,  // Mode strap
  input wire logic       errStrobe,      // Violation pulse
  input wire logic [3:0] faultInitiator, // Requester
  input wire logic [3:0] faultTarget,    // Target
  input wire logic [3:0] faultOpKind,    // Access kind
  input wire logic [3:0] faultClass,     // Class
  input wire logic       awvalid,        // Write address valid
  input wire logic       wvalid,         // Write data valid
  input wire logic       bvalid,         // Write response valid
  input wire logic       irq,            // Interrupt
  input wire logic       opMode,         // Mode bit
  input wire logic       logHeld         // Pair non-zero
);
  logic [2:0] bootCnt;
  // Edges since release; the strap load must not pass for a write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) bootCnt <= 3'h0;
    else if (bootCnt != 3'h7) bootCnt <= bootCnt + 3'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence boot_s;
    $rose(nrst);
  endsequence
  // A clean violation: no write in flight that could clear the pair
  sequence hit_s;
    errStrobe && !awvalid && !wvalid &&
      (|{faultInitiator, faultTarget, faultOpKind, faultClass});
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst |-> !bvalid && !irq && !opMode && !logHeld)
    else $error("outputs active in reset");
  a_mode_boot: assert property (
    boot_s |-> ##4 opMode == $past(modeConfigPin, 4))
    else $error("mode not loaded from strap");
  a_mode_oneway: assert property (opMode |=> opMode)
    else $error("mode left normal");
  a_mode_by_write: assert property (
    $rose(opMode) && bootCnt == 3'h7 |-> $past(bvalid))
    else $error("mode changed without a write");
  a_log_capture: assert property (hit_s |-> ##2 logHeld)
    else $error("violation not logged");
  a_clear_by_write: assert property (
    $fell(logHeld) |-> $past(bvalid))
    else $error("pair cleared without a write");
  a_held_kept: assert property (
    logHeld && !wvalid && !bvalid |=> logHeld)
    else $error("held pair lost");
  a_irq_cause: assert property (
    $rose(irq) |-> $past(errStrobe, 2) || $past(bvalid))
    else $error("interrupt without cause");
endmodule
bind avl_logger avl_logger_asserts i_avl_logger_asserts (.clk, .nrst,
  .modeConfigPin, .errStrobe, .faultInitiator, .faultTarget,
  .faultOpKind, .faultClass, .awvalid, .wvalid, .bvalid, .irq, .opMode,
  .logHeld);

//--- test/tb.sv
// Self-checking bench of the access violation logger
`timescale 1ns/1ps
`include "avl_params.svh"
module tb;
  logic        clk, nrst, modeConfigPin, errStrobe;
  logic        cpuUserState, cpuXirqMask, cpuIrqMask;
  logic [3:0]  faultInitiator, faultTarget, faultOpKind, faultClass;
  logic [23:0] cpuProgCounter;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [3:0]  ini [6];
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, opMode, logHeld;
  logic [15:0] code;
  int          num_errors, num_checks;
  avl_logger i_avl_logger (.clk, .nrst, .modeConfigPin, .errStrobe,
    .faultInitiator, .faultTarget, .faultOpKind, .faultClass,
    .cpuProgCounter, .cpuUserState, .cpuXirqMask, .cpuIrqMask, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .irq, .opMode, .logHeld);
  avl_cpu_model i_avl_cpu_model (.clk, .errStrobe, .faultInitiator,
    .faultTarget, .faultOpKind, .faultClass, .cpuProgCounter,
    .cpuUserState, .cpuXirqMask, .cpuIrqMask);
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // A wait that ran out ends the run as a failure
  task automatic hang(input int n);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  // Ready lines stay high, so every response is taken on its first edge
  task automatic wr(input logic [7:0] i, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    awaddr <= ba(i);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    resp = bresp;
    hang(n);
  endtask
  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rv = rdata;
    resp = rresp;
    hang(n);
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e);
    rd(ba(i));
    chk(rv, e);
  endtask
  initial begin
    // Applied after time-zero start-up so the async resets see the edge
    nrst <= 1'b0;
    modeConfigPin = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, arvalid} = 3'h0;
    bready = 1'b1;
    rready = 1'b1;
    ini = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h1, 4'h3};
    num_errors = 0;
    num_checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // Capture, gap and flag bytes come up empty; strap low gives special
    for (int i = 'h80; i <= 'h88; i++) rc(8'(i), 32'h0);
    rc(8'hFF, 32'h0);
    rc(`AVL_IDX_MODE, 32'h0);
    $display("reset values done");
    // Only special to normal is accepted
    wr(`AVL_IDX_MODE, 32'h0, 4'hF);
    rc(`AVL_IDX_MODE, 32'h0);
    wr(`AVL_IDX_MODE, 32'h1, 4'hF);
    rc(`AVL_IDX_MODE, 32'h1);
    wr(`AVL_IDX_MODE, 32'h0, 4'hF);
    rc(`AVL_IDX_MODE, 32'h1);
    chk({31'h0, opMode}, 32'h1);
    $display("mode done");
    // Every target code and every non-none initiator, kind and class code in turn, each capture cleared before the next
    for (int k = 0; k < 6; k++) begin
      code = {ini[k], 4'(k), 4'(k % 4 + 1), 4'(k % 2 + 1)};
      i_avl_cpu_model.fire(code, 24'hA50000 + 24'(k), 3'(k));
      rc(`AVL_IDX_CODE_HI, {24'h0, code[15:8]});
      rc(`AVL_IDX_CODE_LO, {24'h0, code[7:0]});
      rc(`AVL_IDX_FLAGS_HI, {24'h0, k[2], 7'h0});
      rc(`AVL_IDX_FLAGS_LO, {25'h0, k[1], 1'b0, k[0], 4'h0});
      rc(`AVL_IDX_PC_LO, 32'(k));
      wr(`AVL_IDX_CODE_HI, 32'hFFFF, 4'h3);
      rc(`AVL_IDX_CODE_LO, 32'h0);
    end
    $display("codes done");
    // Second violation is dropped; bad clears and read-only writes too
    i_avl_cpu_model.fire(16'h1342, 24'hABCDEF, 3'h7);
    i_avl_cpu_model.fire(16'h5211, 24'h123456, 3'h0);
    rc(`AVL_IDX_CODE_HI, 32'h13);
    rc(`AVL_IDX_PC_HI, 32'hAB);
    rc(`AVL_IDX_PC_MID, 32'hCD);
    wr(`AVL_IDX_CODE_HI, 32'hFFFE, 4'h3);
    wr(`AVL_IDX_CODE_HI, 32'hFFFF, 4'h1);
    wr(`AVL_IDX_CODE_LO, 32'hFFFF, 4'hF);
    wr(`AVL_IDX_FLAGS_LO, 32'h0, 4'hF);
    wr(`AVL_IDX_GAP_A, 32'hFF, 4'hF);
    chk({30'h0, resp}, {30'h0, `AVL_RESP_OKAY});
    chk({31'h0, logHeld}, 32'h1);
    rc(`AVL_IDX_CODE_LO, 32'h42);
    rc(`AVL_IDX_FLAGS_LO, 32'h50);
    rc(`AVL_IDX_GAP_A, 32'h0);
    $display("hold and clear done");
    // Interrupt masked, unmasked, then its status cleared
    chk({31'h0, irq}, 32'h0);
    rc(`AVL_IDX_IRQ_STAT, 32'h3);
    wr(`AVL_IDX_IRQ_MASK, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`AVL_IDX_IRQ_STAT, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rc(`AVL_IDX_IRQ_STAT, 32'h2);
    rd(12'h400);
    chk({30'h0, resp}, {30'h0, `AVL_RESP_SLVERR});
    rd(ba(8'h03));
    chk({30'h0, resp}, {30'h0, `AVL_RESP_SLVERR});
    wr(8'h03, 32'h1, 4'hF);
    chk({30'h0, resp}, {30'h0, `AVL_RESP_SLVERR});
    rc(`AVL_IDX_IRQ_MASK, 32'h1);
    $display("interrupt and decode done");
    // Reset in mid-run with the strap high
    nrst <= 1'b0;
    modeConfigPin <= 1'b1;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, opMode}, 32'h1);
    rc(`AVL_IDX_CODE_HI, 32'h0);
    chk({31'h0, logHeld}, 32'h0);
    rc(`AVL_IDX_IRQ_MASK, 32'h0);
    $display("second reset done");
    report_and_stop();
  end
endmodule
